//--- verilog/pse_event_register_bank.sv
// Event registers of one four-channel group, read by command code.
// Assumes command strobes and event pulses come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

module pse_event_register_bank (
    // Clock and resets.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic porReset_n,
    // Command port.
    input wire logic cmdRead,
    input wire logic [pse_evt_pkg::CMD_W-1:0] cmdCode,
    output logic [pse_evt_pkg::DATA_W-1:0] readData,
    output logic readValid,
    // Channel state and per-channel event pulses.
    input wire logic [pse_evt_pkg::NCH-1:0] channelOn,
    input wire logic [pse_evt_pkg::NCH-1:0] lineDisconnectEvt,
    input wire logic [pse_evt_pkg::NCH-1:0] overloadCutEvt,
    input wire logic [pse_evt_pkg::NCH-1:0] limitTimerEvt,
    input wire logic [pse_evt_pkg::NCH-1:0] turnOnWindowEvt,
    input wire logic [pse_evt_pkg::NCH-1:0] discoveryErrEvt,
    input wire logic autoMode,
    // Device event pulses.
    input wire logic thermalShutdownEvt,
    input wire logic logicSupplyUndervoltEvt,
    input wire logic logicSupplyWarningEvt,
    input wire logic powerSupplyUndervoltEvt,
    input wire logic fastShutdownEvt,
    input wire logic memoryFaultEvt,
    // Interrupt summary feed and fault cause strobe.
    output logic [2:0] eventPending,
    output logic [pse_evt_pkg::NCH-1:0] powerOnCauseUpdate
);
    import pse_evt_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [NCH-1:0] lineDisconnectFlags;
        logic [NCH-1:0] overloadCutFlags;
        logic [NCH-1:0] currentLimitFaultFlags;
        logic [NCH-1:0] turnOnFaultFlags;
        logic fastShutdownEvent;
        logic memoryFaultFlag;
        logic [NCH-1:0] chanOnPrev;
        logic [DATA_W-1:0] readData;
        logic readValid;
        logic [NCH-1:0] causeUpdate;
    } pse_bank_type;

    pse_bank_type s_reg;
    pse_bank_type s_next;

    logic rstAll_n;
    logic [NCH-1:0] chanOff;
    logic [NCH-1:0] turnOnSet;
    logic [NCH-1:0] causeSet;
    logic clrFault;
    logic clrLimit;
    logic clrSupply;
    logic [3:0] supplyHigh;
    logic [DATA_W-1:0] faultWord;
    logic [DATA_W-1:0] limitWord;
    logic [DATA_W-1:0] supplyWord;

    // Either reset starts the bank; the sticky supply flags see only power-on.
    assign rstAll_n = reset_n & porReset_n;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    assign clrFault = cmdRead && (cmdCode == CMD_FAULT_CLEAR);
    assign clrLimit = cmdRead && (cmdCode == CMD_LIMIT_CLEAR);
    assign clrSupply = cmdRead && (cmdCode == CMD_SUPPLY_CLEAR);

    // ****************************************************************
    // Per-channel turn-off detection
    // ****************************************************************
    for (genvar i = 0; i < NCH; i++) begin : gChan
        // A falling channel enable drops that channel's event bits.
        assign chanOff[i] = s_reg.chanOnPrev[i] & ~channelOn[i];
        // Autonomous mode hides discovery errors from flags and cause.
        assign causeSet[i] = discoveryErrEvt[i] & ~autoMode;
        assign turnOnSet[i] = turnOnWindowEvt[i] | causeSet[i];
    end

    // ****************************************************************
    // Register words
    // ****************************************************************
    assign faultWord = {s_reg.lineDisconnectFlags, s_reg.overloadCutFlags};
    assign limitWord = {s_reg.currentLimitFaultFlags, s_reg.turnOnFaultFlags};
    assign supplyWord = {supplyHigh, SUPPLY_RESERVED, s_reg.fastShutdownEvent,
                         s_reg.memoryFaultFlag};

    // ****************************************************************
    // Preserved supply flags
    // ****************************************************************
    pse_sticky_supply uSticky (
        .clk(clk),
        .porReset_n(porReset_n),
        .setEvt({thermalShutdownEvt, logicSupplyUndervoltEvt, logicSupplyWarningEvt,
                 powerSupplyUndervoltEvt}),
        .clearAll(clrSupply),
        .flags(supplyHigh)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.chanOnPrev = channelOn;
        s_next.readValid = 1'b0;
        s_next.causeUpdate = causeSet;
        // Set wins over both the clearing read and the turn-off clear.
        s_next.lineDisconnectFlags = (s_reg.lineDisconnectFlags & ~chanOff & ~{NCH{clrFault}})
                                     | lineDisconnectEvt;
        // Only the flags change here; the limit and overload timers live elsewhere.
        s_next.overloadCutFlags = (s_reg.overloadCutFlags & ~chanOff & ~{NCH{clrFault}})
                                  | overloadCutEvt;
        s_next.currentLimitFaultFlags = (s_reg.currentLimitFaultFlags & ~chanOff & ~{NCH{clrLimit}})
                                        | limitTimerEvt;
        s_next.turnOnFaultFlags = (s_reg.turnOnFaultFlags & ~chanOff & ~{NCH{clrLimit}})
                                  | turnOnSet;
        s_next.fastShutdownEvent = (s_reg.fastShutdownEvent & ~clrSupply) | fastShutdownEvt;
        s_next.memoryFaultFlag = (s_reg.memoryFaultFlag & ~clrSupply) | memoryFaultEvt;
        // Both codes of a register return the value held before any clear.
        if (cmdRead) begin
            case (cmdCode)
                CMD_FAULT_VIEW, CMD_FAULT_CLEAR: begin
                    s_next.readData = faultWord;
                    s_next.readValid = 1'b1;
                end
                CMD_LIMIT_VIEW, CMD_LIMIT_CLEAR: begin
                    s_next.readData = limitWord;
                    s_next.readValid = 1'b1;
                end
                CMD_SUPPLY_VIEW, CMD_SUPPLY_CLEAR: begin
                    s_next.readData = supplyWord;
                    s_next.readValid = 1'b1;
                end
                default: begin
                    s_next.readValid = 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk or negedge rstAll_n) begin
        if (!rstAll_n) begin
            s_reg <= '{lineDisconnectFlags: CHAN_FLAGS_RESET,
                       overloadCutFlags: CHAN_FLAGS_RESET,
                       currentLimitFaultFlags: CHAN_FLAGS_RESET,
                       turnOnFaultFlags: CHAN_FLAGS_RESET,
                       fastShutdownEvent: SUPPLY_LOW_RESET[1],
                       memoryFaultFlag: SUPPLY_LOW_RESET[0],
                       chanOnPrev: CHAN_FLAGS_RESET,
                       readData: READ_DATA_RESET,
                       readValid: 1'b0,
                       causeUpdate: CHAN_FLAGS_RESET};
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign readData = s_reg.readData;
    assign readValid = s_reg.readValid;
    assign powerOnCauseUpdate = s_reg.causeUpdate;
    // Any set bit holds its register's request to the summary logic.
    assign eventPending[PEND_FAULT] = |faultWord;
    assign eventPending[PEND_LIMIT] = |limitWord;
    assign eventPending[PEND_SUPPLY] = |supplyWord;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_readFault;
        @(posedge clk) disable iff (!rstAll_n)
        cmdRead && (cmdCode == CMD_FAULT_VIEW || cmdCode == CMD_FAULT_CLEAR)
        |=> readValid && (readData == $past(faultWord));
    endproperty
    a_readFault: assert property (p_readFault) else $error("Fault register read wrong.");

    property p_readLimit;
        @(posedge clk) disable iff (!rstAll_n)
        cmdRead && (cmdCode == CMD_LIMIT_VIEW || cmdCode == CMD_LIMIT_CLEAR)
        |=> readValid && (readData == $past(limitWord));
    endproperty
    a_readLimit: assert property (p_readLimit) else $error("Limit register read wrong.");

    property p_readSupply;
        @(posedge clk) disable iff (!rstAll_n)
        cmdRead && (cmdCode == CMD_SUPPLY_VIEW || cmdCode == CMD_SUPPLY_CLEAR)
        |=> readValid && (readData[3:2] == 2'h0) && (readData == $past(supplyWord));
    endproperty
    a_readSupply: assert property (p_readSupply) else $error("Supply register read wrong.");

    property p_clearFault;
        @(posedge clk) disable iff (!rstAll_n)
        clrFault && !(|lineDisconnectEvt) && !(|overloadCutEvt) |=> faultWord == 8'h00;
    endproperty
    a_clearFault: assert property (p_clearFault) else $error("Clearing read left bits set.");

    property p_viewKeeps;
        @(posedge clk) disable iff (!rstAll_n)
        cmdRead && (cmdCode == CMD_LIMIT_VIEW) && !(|chanOff)
        |=> (limitWord & $past(limitWord)) == $past(limitWord);
    endproperty
    a_viewKeeps: assert property (p_viewKeeps) else $error("Plain read cleared bits.");

    property p_offClears;
        @(posedge clk) disable iff (!rstAll_n)
        chanOff[1] && !lineDisconnectEvt[1] && !overloadCutEvt[1] && !limitTimerEvt[1] && !turnOnSet[1]
        |=> !faultWord[5] && !faultWord[1] && !limitWord[5] && !limitWord[1];
    endproperty
    a_offClears: assert property (p_offClears) else $error("Turned-off channel kept flags.");

    property p_autoQuiet;
        @(posedge clk) disable iff (!rstAll_n)
        autoMode && discoveryErrEvt[2] && !turnOnWindowEvt[2] && !limitWord[2]
        |=> !limitWord[2] && !powerOnCauseUpdate[2];
    endproperty
    a_autoQuiet: assert property (p_autoQuiet) else $error("Discovery error flagged in autonomous mode.");

    property p_setWins;
        @(posedge clk) disable iff (!rstAll_n)
        clrFault && overloadCutEvt[3] |=> faultWord[3];
    endproperty
    a_setWins: assert property (p_setWins) else $error("Event lost on clearing read.");

    property p_release;
        @(posedge clk) disable iff (!rstAll_n)
        clrLimit && !(|limitTimerEvt) && !(|turnOnSet) |=> !eventPending[PEND_LIMIT];
    endproperty
    a_release: assert property (p_release) else $error("Clearing read did not release request.");

    property p_clearFromReset;
        @(posedge clk) disable iff (!rstAll_n)
        $rose(rstAll_n) |-> (faultWord == 8'h00) && (limitWord == 8'h00);
    endproperty
    a_clearFromReset: assert property (p_clearFromReset) else $error("Channel flags not zero after reset.");

    property p_clearLimit;
        @(posedge clk) disable iff (!rstAll_n)
        clrLimit && !(|limitTimerEvt) && !(|turnOnSet) |=> limitWord == 8'h00;
    endproperty
    a_clearLimit: assert property (p_clearLimit) else $error("Limit clearing read left bits set.");

    property p_clearSupply;
        @(posedge clk) disable iff (!rstAll_n)
        clrSupply && !thermalShutdownEvt && !logicSupplyUndervoltEvt && !logicSupplyWarningEvt
        && !powerSupplyUndervoltEvt && !fastShutdownEvt && !memoryFaultEvt |=> supplyWord == 8'h00;
    endproperty
    a_clearSupply: assert property (p_clearSupply) else $error("Supply clearing read left bits set.");

    property p_viewFaultKeeps;
        @(posedge clk) disable iff (!rstAll_n)
        cmdRead && (cmdCode == CMD_FAULT_VIEW) && !(|chanOff)
        |=> (faultWord & $past(faultWord)) == $past(faultWord);
    endproperty
    a_viewFaultKeeps: assert property (p_viewFaultKeeps) else $error("Plain fault read cleared bits.");

    property p_unmapped;
        @(posedge clk) disable iff (!rstAll_n)
        cmdRead && (cmdCode < CMD_FAULT_VIEW || cmdCode > CMD_SUPPLY_CLEAR) |=> !readValid;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped code answered.");

    property p_idleNoValid;
        @(posedge clk) disable iff (!rstAll_n)
        !cmdRead |=> !readValid;
    endproperty
    a_idleNoValid: assert property (p_idleNoValid) else $error("Read valid without a command.");

    property p_dataHolds;
        @(posedge clk) disable iff (!rstAll_n)
        !cmdRead |=> $stable(readData);
    endproperty
    a_dataHolds: assert property (p_dataHolds) else $error("Read data moved without a command.");

    property p_disconnectSet;
        @(posedge clk) disable iff (!rstAll_n)
        |lineDisconnectEvt
        |=> (faultWord[7:4] & $past(lineDisconnectEvt)) == $past(lineDisconnectEvt);
    endproperty
    a_disconnectSet: assert property (p_disconnectSet) else $error("Disconnect event not latched.");

    property p_overloadSet;
        @(posedge clk) disable iff (!rstAll_n)
        |overloadCutEvt
        |=> (faultWord[3:0] & $past(overloadCutEvt)) == $past(overloadCutEvt);
    endproperty
    a_overloadSet: assert property (p_overloadSet) else $error("Overload event not latched.");

    property p_limitSet;
        @(posedge clk) disable iff (!rstAll_n)
        |limitTimerEvt
        |=> (limitWord[7:4] & $past(limitTimerEvt)) == $past(limitTimerEvt);
    endproperty
    a_limitSet: assert property (p_limitSet) else $error("Limit event not latched.");

    property p_startSet;
        @(posedge clk) disable iff (!rstAll_n)
        |turnOnWindowEvt
        |=> (limitWord[3:0] & $past(turnOnWindowEvt)) == $past(turnOnWindowEvt);
    endproperty
    a_startSet: assert property (p_startSet) else $error("Turn-on timeout not latched.");

    property p_causePulse;
        @(posedge clk) disable iff (!rstAll_n)
        !autoMode && discoveryErrEvt[2] |=> powerOnCauseUpdate[2] && limitWord[2];
    endproperty
    a_causePulse: assert property (p_causePulse) else $error("Discovery error not reported.");

    property p_fastSet;
        @(posedge clk) disable iff (!rstAll_n)
        fastShutdownEvt |=> supplyWord[SUP_FAST_SHUTDOWN_BIT];
    endproperty
    a_fastSet: assert property (p_fastSet) else $error("Fast shutdown event not latched.");

    property p_memSet;
        @(posedge clk) disable iff (!rstAll_n)
        memoryFaultEvt |=> supplyWord[SUP_MEMORY_FAULT_BIT];
    endproperty
    a_memSet: assert property (p_memSet) else $error("Memory fault not latched.");

endmodule // pse_event_register_bank

`default_nettype wire

//--- verilog/pse_evt_pkg.sv
// Constants for the channel and device event register bank.
// Assumes one device clock and command codes decoded inside the bank.
`default_nettype none

package pse_evt_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int NCH = 4;
    localparam int CMD_W = 8;
    localparam int DATA_W = 8;

    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [CMD_W-1:0] CMD_FAULT_VIEW = 8'h06;
    localparam logic [CMD_W-1:0] CMD_FAULT_CLEAR = 8'h07;
    localparam logic [CMD_W-1:0] CMD_LIMIT_VIEW = 8'h08;
    localparam logic [CMD_W-1:0] CMD_LIMIT_CLEAR = 8'h09;
    localparam logic [CMD_W-1:0] CMD_SUPPLY_VIEW = 8'h0a;
    localparam logic [CMD_W-1:0] CMD_SUPPLY_CLEAR = 8'h0b;

    // ****************************************************************
    // Field positions of the supply and device register
    // ****************************************************************
    localparam int SUP_THERMAL_BIT = 7;
    localparam int SUP_LOGIC_UV_BIT = 6;
    localparam int SUP_LOGIC_WARN_BIT = 5;
    localparam int SUP_POWER_UV_BIT = 4;
    localparam int SUP_FAST_SHUTDOWN_BIT = 1;
    localparam int SUP_MEMORY_FAULT_BIT = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [NCH-1:0] CHAN_FLAGS_RESET = 4'h0;
    // Thermal, logic undervolt, logic warning, power undervolt.
    localparam logic [3:0] SUPPLY_HIGH_POR = 4'h7;
    localparam logic [1:0] SUPPLY_LOW_RESET = 2'h0;
    localparam logic [1:0] SUPPLY_RESERVED = 2'h0;
    localparam logic [DATA_W-1:0] READ_DATA_RESET = 8'h00;

    // Index of each register in the pending vector.
    localparam int PEND_FAULT = 0;
    localparam int PEND_LIMIT = 1;
    localparam int PEND_SUPPLY = 2;

endpackage

`default_nettype wire

//--- verilog/pse_sticky_supply.sv
// Supply flags that survive a pin reset and start only at power-on.
// Assumes the set and clear strobes come from the device clock domain.
`timescale 1ns/1ps
`default_nettype none

module pse_sticky_supply (
    // Clock and power-on reset.
    input wire logic clk,
    input wire logic porReset_n,
    // Event strobes, bit 3 thermal down to bit 0 power undervolt.
    input wire logic [3:0] setEvt,
    input wire logic clearAll,
    // Latched flags.
    output logic [3:0] flags
);
    import pse_evt_pkg::*;

    typedef struct packed {
        logic [3:0] flags;
    } pse_sticky_type;

    pse_sticky_type s_reg;
    pse_sticky_type s_next;

    // ****************************************************************
    // Latching
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        // A new event outweighs a clear in the same cycle.
        s_next.flags = (s_reg.flags & ~{4{clearAll}}) | setEvt;
    end

    // Only power-on reset starts these flags; the pin reset never reaches here.
    always_ff @(posedge clk or negedge porReset_n) begin
        if (!porReset_n) begin
            s_reg <= '{flags: SUPPLY_HIGH_POR};
        end else begin
            s_reg <= s_next;
        end
    end

    assign flags = s_reg.flags;

    property p_stickySet;
        @(posedge clk) disable iff (!porReset_n)
        setEvt[0] |=> flags[0];
    endproperty
    a_stickySet: assert property (p_stickySet) else $error("Supply event lost on clear.");

endmodule // pse_sticky_supply

`default_nettype wire

//--- verification/pse_evt_host.sv
// Host controller model that issues command reads to the event register bank.
// Assumes its task is called just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none

module pse_evt_host (
    // Clock.
    input wire logic clk,
    // Command port.
    output var logic cmdRead,
    output var logic [7:0] cmdCode,
    input wire logic [7:0] readData,
    input wire logic readValid
);
    initial begin
        cmdRead = 1'b0;
        cmdCode = 8'h00;
    end

    // Inrush when the start fault and the power enable change are both set.
    function automatic logic isInrush(input logic startFault, input logic enableChange);
        return startFault & enableChange;
    endfunction

    // The strobe stands through one taking edge and the answer is taken just after it.
    // An idle edge follows, so a second call never raises the strobe this one just lowered.
    task automatic readReg(input logic [7:0] code, output logic [7:0] data, output logic valid);
        cmdRead = 1'b1;
        cmdCode = code;
        @(posedge clk);
        #1;
        cmdRead = 1'b0;
        cmdCode = ~code;
        data = readData;
        valid = readValid;
        @(posedge clk);
        #1;
    endtask
endmodule // pse_evt_host

`default_nettype wire

//--- verification/pse_event_register_bank_test.sv
// Self-checking bench for the event register bank.
// Assumes the package pse_evt_pkg and the host model pse_evt_host.
`timescale 1ns/1ps
`default_nettype none

module pse_event_register_bank_test;
    import pse_evt_pkg::*;
    logic clk, reset_n, porReset_n, cmdRead, readValid, autoMode;
    logic [7:0] cmdCode, readData;
    logic [3:0] channelOn, discEvt, ovlEvt, limEvt, startEvt, discoErrEvt, causeUpd;
    logic tsdEvt, vduvEvt, warnEvt, vpuvEvt, fastEvt, memEvt;
    logic [2:0] eventPending;
    int err_total = 0;
    int checked = 0;

    pse_event_register_bank uut (.clk(clk), .reset_n(reset_n), .porReset_n(porReset_n),
        .cmdRead(cmdRead), .cmdCode(cmdCode), .readData(readData), .readValid(readValid),
        .channelOn(channelOn), .lineDisconnectEvt(discEvt), .overloadCutEvt(ovlEvt),
        .limitTimerEvt(limEvt), .turnOnWindowEvt(startEvt), .discoveryErrEvt(discoErrEvt),
        .autoMode(autoMode), .thermalShutdownEvt(tsdEvt), .logicSupplyUndervoltEvt(vduvEvt),
        .logicSupplyWarningEvt(warnEvt), .powerSupplyUndervoltEvt(vpuvEvt),
        .fastShutdownEvt(fastEvt), .memoryFaultEvt(memEvt), .eventPending(eventPending),
        .powerOnCauseUpdate(causeUpd));
    pse_evt_host host (.clk(clk), .cmdRead(cmdRead), .cmdCode(cmdCode), .readData(readData),
        .readValid(readValid));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic report_and_stop();
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.readReg(code, d, v);
        chk("readValid", 8'h01, {7'h00, v});
        chk("readData", exp, d);
    endtask

    task automatic clearEvts();
        {discEvt, ovlEvt, limEvt, startEvt, discoErrEvt} = 20'h00000;
        {tsdEvt, vduvEvt, warnEvt, vpuvEvt, fastEvt, memEvt} = 6'h00;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic sc_power_on();
        rd(CMD_FAULT_VIEW, 8'h00);
        rd(CMD_LIMIT_VIEW, 8'h00);
        rd(CMD_SUPPLY_VIEW, 8'h70);
        chk("eventPending", 8'h04, {5'h00, eventPending});
        rd(CMD_SUPPLY_CLEAR, 8'h70);
        chk("eventPending", 8'h00, {5'h00, eventPending});
        rd(CMD_SUPPLY_VIEW, 8'h00);
    endtask

    task automatic sc_fault();
        discEvt = 4'h4;
        ovlEvt = 4'h1;
        tick(1);
        clearEvts();
        chk("eventPending", 8'h01, {5'h00, eventPending});
        rd(CMD_FAULT_VIEW, 8'h41);
        rd(CMD_FAULT_VIEW, 8'h41);
        rd(CMD_FAULT_CLEAR, 8'h41);
        chk("eventPending", 8'h00, {5'h00, eventPending});
        rd(CMD_FAULT_VIEW, 8'h00);
    endtask

    task automatic sc_limit();
        limEvt = 4'h8;
        startEvt = 4'h2;
        tick(1);
        clearEvts();
        chk("eventPending", 8'h02, {5'h00, eventPending});
        rd(CMD_LIMIT_VIEW, 8'h82);
        chk("inrush", 8'h01, {7'h00, host.isInrush(readData[1], 1'b1)});
        chk("inrush", 8'h00, {7'h00, host.isInrush(readData[1], 1'b0)});
        rd(CMD_LIMIT_CLEAR, 8'h82);
        rd(CMD_LIMIT_VIEW, 8'h00);
    endtask

    task automatic sc_discovery();
        autoMode = 1'b1;
        discoErrEvt = 4'h4;
        tick(1);
        discoErrEvt = 4'h0;
        chk("causeUpd", 8'h00, {4'h0, causeUpd});
        rd(CMD_LIMIT_VIEW, 8'h00);
        autoMode = 1'b0;
        discoErrEvt = 4'h4;
        tick(1);
        discoErrEvt = 4'h0;
        chk("causeUpd", 8'h04, {4'h0, causeUpd});
        tick(1);
        chk("causeUpd", 8'h00, {4'h0, causeUpd});
        rd(CMD_LIMIT_CLEAR, 8'h04);
    endtask

    task automatic sc_supply();
        {tsdEvt, fastEvt, memEvt} = 3'h7;
        tick(1);
        clearEvts();
        rd(CMD_SUPPLY_VIEW, 8'h83);
        rd(CMD_SUPPLY_CLEAR, 8'h83);
        {vduvEvt, warnEvt, vpuvEvt} = 3'h7;
        tick(1);
        clearEvts();
        chk("eventPending", 8'h04, {5'h00, eventPending});
        rd(CMD_SUPPLY_CLEAR, 8'h70);
        rd(CMD_SUPPLY_VIEW, 8'h00);
    endtask

    task automatic sc_channel_off();
        discEvt = 4'h2;
        limEvt = 4'h2;
        ovlEvt = 4'h1;
        tick(1);
        clearEvts();
        channelOn = 4'hd;
        tick(2);
        rd(CMD_FAULT_VIEW, 8'h01);
        rd(CMD_LIMIT_VIEW, 8'h00);
        channelOn = 4'hf;
        rd(CMD_FAULT_CLEAR, 8'h01);
    endtask

    task automatic sc_clear_race();
        discEvt = 4'h1;
        tick(1);
        discEvt = 4'h0;
        ovlEvt = 4'h8;
        rd(CMD_FAULT_CLEAR, 8'h10);
        ovlEvt = 4'h0;
        rd(CMD_FAULT_VIEW, 8'h08);
        rd(CMD_FAULT_CLEAR, 8'h08);
    endtask

    task automatic sc_pin_reset();
        tsdEvt = 1'b1;
        ovlEvt = 4'h2;
        memEvt = 1'b1;
        tick(1);
        clearEvts();
        reset_n = 1'b0;
        tick(2);
        reset_n = 1'b1;
        tick(1);
        rd(CMD_FAULT_VIEW, 8'h00);
        rd(CMD_SUPPLY_VIEW, 8'h80);
        rd(CMD_SUPPLY_CLEAR, 8'h80);
    endtask

    task automatic sc_unmapped();
        logic [7:0] d;
        logic v;
        host.readReg(8'h0c, d, v);
        chk("readValid", 8'h00, {7'h00, v});
        host.readReg(8'h05, d, v);
        chk("readValid", 8'h00, {7'h00, v});
        rd(CMD_FAULT_VIEW, 8'h00);
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        reset_n = 1'b0;
        porReset_n = 1'b0;
        autoMode = 1'b0;
        channelOn = 4'hf;
        clearEvts();
        tick(16);
        reset_n = 1'b1;
        porReset_n = 1'b1;
        tick(1);
        sc_power_on();
        sc_fault();
        sc_limit();
        sc_discovery();
        sc_supply();
        sc_channel_off();
        sc_clear_race();
        sc_pin_reset();
        sc_unmapped();
        report_and_stop();
    end

    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
endmodule // pse_event_register_bank_test

`default_nettype wire
